// File: src/rqfd_consts.svh
// Constants for the receive queue frame descriptor builder
`ifndef RQFD_CONSTS_SVH
`define RQFD_CONSTS_SVH

// ----------------------------------------------------------------
// Descriptor layout in queue memory
// ----------------------------------------------------------------
`define RQFD_OFF_STATUS   12'h000
`define RQFD_OFF_LENGTH   12'h002
`define RQFD_OFF_DATA     12'h004
`define RQFD_HDR_BYTES    12'h004
`define RQFD_MAX_DATA     11'h77c
`define RQFD_HDR_ROOM     12'h006

// ----------------------------------------------------------------
// Frame classification limits
// ----------------------------------------------------------------
`define RQFD_ETYPE_MIN    16'h05dc
`define RQFD_MAX_FRAME    12'h5ee
`define RQFD_MIN_FRAME    12'h040
`define RQFD_FCS_BYTES    12'h004
`define RQFD_DA_LAST      12'h005
`define RQFD_TYPE_HI      12'h00c
`define RQFD_TYPE_LO      12'h00d
`define RQFD_CNT_SAT      12'hfff

// ----------------------------------------------------------------
// Status word bit positions and source port codes
// ----------------------------------------------------------------
`define RQFD_ST_VALID     15
`define RQFD_ST_PORT_HI   9
`define RQFD_ST_PORT_LO   8
`define RQFD_ST_BCAST     7
`define RQFD_ST_MCAST     6
`define RQFD_ST_UCAST     5
`define RQFD_ST_ETYPE     3
`define RQFD_ST_LONG      2
`define RQFD_ST_RUNT      1
`define RQFD_ST_CRC       0
`define RQFD_LEN_MSB      10
`define RQFD_PORT_ONE     2'h1
`define RQFD_PORT_TWO     2'h2

// ----------------------------------------------------------------
// APB register map and control bits
// ----------------------------------------------------------------
`define RQFD_REG_CTRL     8'h00
`define RQFD_REG_STATUS   8'h04
`define RQFD_REG_LENGTH   8'h08
`define RQFD_REG_RDOFS    8'h0c
`define RQFD_REG_RDDATA   8'h10
`define RQFD_REG_RELEASE  8'h14
`define RQFD_REG_DROPS    8'h18
`define RQFD_REG_LEVEL    8'h1c
`define RQFD_CTRL_PASSBAD 0
`define RQFD_CTRL_STRIP   1
`define RQFD_RDOFS_STEP   11'h002

`endif

// File: src/rqfd_pkg.sv
// Types shared by the receive queue frame descriptor builder
package rqfd_pkg;

  // One byte of a received frame as handed over by the MAC
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       port_two;
    logic       fcs_bad;
    logic       collided;
  } rqfd_rx_beat_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECV,
    ST_FINISH
  } rqfd_state_t;

endpackage

// File: src/rqfd_framer.sv
// Receive queue framer: builds descriptors in packet memory, APB access
`timescale 1ns/10ps
`default_nettype none
`include "rqfd_consts.svh"

// Function
// - status at 0, count at 2, data from 4
// - at most 1916 data bytes per entry
// - drop FCS bytes when stripping is enabled
// - status describes the frame at queue head
// - bit 15 set only for complete frames
// - bits 9-8 encode port, 01 or 10
// - bit 7 marks broadcast destination
// - bit 6 marks multicast, broadcast included
// - bit 5 marks unicast destination
// - bit 3 set when type exceeds 1500
// - type bit meaningless for runt frames
// - bit 2 set above 1518 bytes
// - oversized frames kept only with pass-bad
// - oversized frames are never truncated
// - bit 1 marks collision or early end
// - runt frames kept only with pass-bad
// - bit 0 marks a bad FCS
// - FCS-error frames kept only with pass-bad
// - count word bits 10-0, 15-11 reserved
module rqfd_framer #(
  parameter int QDEPTH = 4096,
  parameter int AW     = 12
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rx_valid,
  input  wire rqfd_pkg::rqfd_rx_beat_t rx_beat,
  output logic                       rx_ready
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // A byte count of 11 bits and 12-bit frame offsets need 4 KB at least
  if (QDEPTH != (1 << AW) || AW < 12 || AW > 16) begin : g_bad_depth
    $error("rqfd_framer: QDEPTH must be 2**AW with AW in 12..16");
  end

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0]            mem [QDEPTH];
  rqfd_pkg::rqfd_state_t state;
  rqfd_pkg::rqfd_state_t next_state;
  logic [AW-1:0]         head;
  logic [AW-1:0]         commit;
  logic [AW-1:0]         base;
  logic [AW-1:0]         wptr;
  logic [11:0]           rcv_cnt;
  logic [10:0]           stored_cnt;
  logic [7:0]            dly [4];
  logic                  strip_frame;
  logic                  bcast;
  logic                  mcast;
  logic [7:0]            type_hi;
  logic [7:0]            type_lo;
  logic                  port_two;
  logic                  fcs_bad;
  logic                  collided;
  logic                  no_room;
  logic                  too_big;
  logic                  pass_bad;
  logic                  strip_en;
  logic [10:0]           rd_ofs;
  logic [15:0]           drops;

  function automatic logic [15:0] word_at(input logic [AW-1:0] a);
    logic [AW-1:0] a1;
    a1 = a + AW'(1);
    word_at = {mem[a1], mem[a]};
  endfunction

  function automatic logic [AW-1:0] entry_size(input logic [10:0] n);
    entry_size = AW'(`RQFD_HDR_BYTES) + AW'(n) + AW'(n[0]);
  endfunction

  // ----------------------------------------------------------------
  // Receive side decode
  // ----------------------------------------------------------------
  logic          accept;
  logic          first;
  logic [11:0]   idx;
  logic          eff_strip;
  logic [7:0]    wr_byte;
  logic          wr_cand;
  logic [AW-1:0] free_now;
  logic [AW-1:0] free_start;
  logic          room_fail;
  logic          size_fail;
  logic          do_write;

  assign accept     = rx_valid && rx_ready;
  assign first      = (state == rqfd_pkg::ST_IDLE);
  assign idx        = first ? 12'h000 : rcv_cnt;
  assign eff_strip  = first ? strip_en : strip_frame;
  // Stripping delays the stream by four bytes so the FCS never lands
  assign wr_byte    = eff_strip ? dly[3] : rx_beat.data;
  assign wr_cand    = !eff_strip || (idx >= `RQFD_FCS_BYTES);
  assign free_start = head - commit - AW'(1);
  assign free_now   = head - wptr - AW'(1);
  // Two spare bytes are kept so an odd frame can still be padded
  assign room_fail  = (first && (free_start < AW'(`RQFD_HDR_ROOM))) ||
                      (free_now < AW'(2));
  assign size_fail  = (stored_cnt == `RQFD_MAX_DATA) && !first;
  assign do_write   = accept && wr_cand && !room_fail && !size_fail &&
                      !(no_room && !first) && !(too_big && !first);

  // ----------------------------------------------------------------
  // Frame classification at the end of reception
  // ----------------------------------------------------------------
  logic        is_etype;
  logic        is_long;
  logic        is_runt;
  logic        bad_frame;
  logic        keep;
  logic [15:0] status_word;
  logic [15:0] length_word;

  assign is_etype  = (rcv_cnt > `RQFD_TYPE_LO) &&
                     ({type_hi, type_lo} > `RQFD_ETYPE_MIN);
  assign is_long   = rcv_cnt > `RQFD_MAX_FRAME;
  assign is_runt   = collided || (rcv_cnt < `RQFD_MIN_FRAME);
  assign bad_frame = is_long || is_runt || fcs_bad;
  assign keep      = !no_room && !too_big &&
                     (pass_bad || !bad_frame);

  always_comb begin
    status_word = 16'h0000;
    status_word[`RQFD_ST_VALID] = 1'b1;
    status_word[`RQFD_ST_PORT_HI:`RQFD_ST_PORT_LO] =
      port_two ? `RQFD_PORT_TWO : `RQFD_PORT_ONE;
    status_word[`RQFD_ST_BCAST] = bcast;
    status_word[`RQFD_ST_MCAST] = mcast;
    status_word[`RQFD_ST_UCAST] = !mcast;
    status_word[`RQFD_ST_ETYPE] = is_etype;
    status_word[`RQFD_ST_LONG]  = is_long;
    status_word[`RQFD_ST_RUNT]  = is_runt;
    status_word[`RQFD_ST_CRC]   = fcs_bad;
    length_word = 16'h0000;
    length_word[`RQFD_LEN_MSB:0] = stored_cnt;
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      rqfd_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = rx_beat.last ? rqfd_pkg::ST_FINISH
                                    : rqfd_pkg::ST_RECV;
        end
      end
      rqfd_pkg::ST_RECV: begin
        if (accept && rx_beat.last) begin
          next_state = rqfd_pkg::ST_FINISH;
        end
      end
      rqfd_pkg::ST_FINISH: begin
        next_state = rqfd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= rqfd_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The finish cycle writes the header, so no byte may arrive then
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (next_state != rqfd_pkg::ST_FINISH);
    end
  end

  // ----------------------------------------------------------------
  // Per-frame bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rcv_cnt     <= 12'h000;
      strip_frame <= 1'b0;
      port_two    <= 1'b0;
      fcs_bad     <= 1'b0;
      collided    <= 1'b0;
    end else if (accept) begin
      if (rcv_cnt != `RQFD_CNT_SAT || first) begin
        rcv_cnt <= idx + 12'h001;
      end
      if (first) begin
        strip_frame <= strip_en;
        port_two    <= rx_beat.port_two;
      end
      if (rx_beat.last) begin
        fcs_bad  <= rx_beat.fcs_bad;
        collided <= rx_beat.collided;
      end
    end
  end

  // Destination class and length/type taken from the header bytes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bcast   <= 1'b0;
      mcast   <= 1'b0;
      type_hi <= 8'h00;
      type_lo <= 8'h00;
    end else if (accept) begin
      if (first) begin
        mcast <= rx_beat.data[0];
        bcast <= (rx_beat.data == 8'hff);
      end else if (idx <= `RQFD_DA_LAST) begin
        bcast <= bcast && (rx_beat.data == 8'hff);
      end
      if (idx == `RQFD_TYPE_HI) begin
        type_hi <= rx_beat.data;
      end
      if (idx == `RQFD_TYPE_LO) begin
        type_lo <= rx_beat.data;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        dly[i] <= 8'h00;
      end
    end else if (accept) begin
      dly[0] <= rx_beat.data;
      for (int i = 1; i < 4; i++) begin
        dly[i] <= dly[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write pointers and drop decisions
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      base       <= '0;
      wptr       <= AW'(`RQFD_OFF_DATA);
      commit     <= '0;
      stored_cnt <= 11'h000;
      no_room    <= 1'b0;
      too_big    <= 1'b0;
    end else if (state == rqfd_pkg::ST_FINISH) begin
      if (keep) begin
        commit <= base + entry_size(stored_cnt);
        base   <= base + entry_size(stored_cnt);
        wptr   <= base + entry_size(stored_cnt) + AW'(`RQFD_OFF_DATA);
      end else begin
        wptr   <= base + AW'(`RQFD_OFF_DATA);
      end
    end else if (accept) begin
      if (first) begin
        stored_cnt <= 11'h000;
        no_room    <= 1'b0;
        too_big    <= 1'b0;
      end
      if (accept && wr_cand && room_fail) begin
        no_room <= 1'b1;
      end
      if (accept && wr_cand && size_fail) begin
        too_big <= 1'b1;
      end
      if (do_write) begin
        wptr       <= wptr + AW'(1);
        stored_cnt <= (first ? 11'h000 : stored_cnt) + 11'h001;
      end
    end
  end

  // Data bytes follow the header; header lands once the frame is judged
  always_ff @(posedge sys_clk) begin
    if (do_write) begin
      mem[wptr] <= wr_byte;
    end
    if (state == rqfd_pkg::ST_FINISH && keep) begin
      mem[base + AW'(`RQFD_OFF_STATUS)]          <= status_word[7:0];
      mem[base + AW'(`RQFD_OFF_STATUS) + AW'(1)] <= status_word[15:8];
      mem[base + AW'(`RQFD_OFF_LENGTH)]          <= length_word[7:0];
      mem[base + AW'(`RQFD_OFF_LENGTH) + AW'(1)] <= length_word[15:8];
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic          setup;
  logic          wr_access;
  logic          present;
  logic [15:0]   head_status;
  logic [15:0]   head_length;
  logic [AW-1:0] rd_addr;

  assign setup       = psel && !penable;
  assign wr_access   = psel && penable && pready && pwrite;
  // An empty queue or a frame still arriving shows no valid status
  assign present     = (head != commit);
  assign head_status = present ? word_at(head + AW'(`RQFD_OFF_STATUS))
                               : 16'h0000;
  assign head_length = present ? word_at(head + AW'(`RQFD_OFF_LENGTH))
                               : 16'h0000;
  assign rd_addr     = head + AW'(`RQFD_OFF_DATA) + AW'(rd_ofs);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr)
          `RQFD_REG_CTRL: begin
            prdata[`RQFD_CTRL_PASSBAD] <= pass_bad;
            prdata[`RQFD_CTRL_STRIP]   <= strip_en;
          end
          `RQFD_REG_STATUS:  prdata[15:0] <= head_status;
          `RQFD_REG_LENGTH:  prdata[15:0] <= head_length;
          `RQFD_REG_RDOFS:   prdata[10:0] <= rd_ofs;
          `RQFD_REG_RDDATA: begin
            prdata[15:0] <= present ? word_at(rd_addr) : 16'h0000;
          end
          `RQFD_REG_RELEASE: prdata <= 32'h0000_0000;
          `RQFD_REG_DROPS:   prdata[15:0] <= drops;
          `RQFD_REG_LEVEL:   prdata[AW-1:0] <= commit - head;
          default:           pslverr <= 1'b1;
        endcase
      end else if (setup) begin
        unique case (paddr)
          `RQFD_REG_CTRL, `RQFD_REG_RDOFS, `RQFD_REG_RELEASE: begin
            pslverr <= 1'b0;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pass_bad <= 1'b0;
      strip_en <= 1'b0;
    end else if (wr_access && paddr == `RQFD_REG_CTRL) begin
      pass_bad <= pwdata[`RQFD_CTRL_PASSBAD];
      strip_en <= pwdata[`RQFD_CTRL_STRIP];
    end
  end

  // Reading the data window walks forward one word per access
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_ofs <= 11'h000;
      head   <= '0;
    end else if (wr_access && paddr == `RQFD_REG_RELEASE) begin
      if (pwdata[0] && present) begin
        head   <= head + entry_size(head_length[`RQFD_LEN_MSB:0]);
        rd_ofs <= 11'h000;
      end
    end else if (wr_access && paddr == `RQFD_REG_RDOFS) begin
      rd_ofs <= {pwdata[10:1], 1'b0};
    end else if (psel && penable && pready && !pwrite &&
                 paddr == `RQFD_REG_RDDATA) begin
      rd_ofs <= rd_ofs + `RQFD_RDOFS_STEP;
    end
  end

  // Saturating count of frames thrown away; never cleared by software
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      drops <= 16'h0000;
    end else if (state == rqfd_pkg::ST_FINISH && !keep &&
                 drops != 16'hffff) begin
      drops <= drops + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// File: sim/rqfd_framer_assertions.sv
// Port-level checker for the receive queue framer
`timescale 1ns/10ps
`default_nettype none
module rqfd_framer_assertions (
  input wire logic                    sys_clk,
  input wire logic                    reset,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    rx_valid,
  input wire rqfd_pkg::rqfd_rx_beat_t rx_beat,
  input wire logic                    rx_ready
);
  logic st_rd;
  logic ln_rd;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Address is still held in the access cycle, so it names the register
  assign st_rd = pready && !pslverr && !pwrite && paddr == 8'h04;
  assign ln_rd = pready && !pslverr && !pwrite && paddr == 8'h08;
  chk_ready_after_setup:
    assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_no_cause:
    assert property (!(psel && !penable) |=> !pready)
    else $error("ready without setup");
  chk_err_unmapped:
    assert property (psel && !penable && paddr > 8'h1c |=> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped:
    assert property (psel && !penable && paddr <= 8'h1c
                     && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  chk_err_data_zero:
    assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  chk_idle_data_zero:
    assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_finish_gap:
    assert property (rx_valid && rx_ready && rx_beat.last
                     |=> !rx_ready ##1 rx_ready)
    else $error("finish gap not one cycle");
  chk_status_reserved:
    assert property (st_rd |-> prdata[31:16] == 16'h0
                     && prdata[14:10] == 5'h0 && !prdata[4])
    else $error("status reserved bits set");
  chk_length_reserved:
    assert property (ln_rd |-> prdata[31:11] == 21'h0)
    else $error("length reserved bits set");
  chk_port_code:
    assert property (st_rd && prdata[15] |-> prdata[9:8] == 2'h1
                     || prdata[9:8] == 2'h2)
    else $error("bad port code");
  chk_bcast_mcast:
    assert property (st_rd && prdata[7] |-> prdata[6] && !prdata[5])
    else $error("broadcast without multicast");
endmodule

bind rqfd_framer rqfd_framer_assertions chk_u (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .rx_beat(rx_beat), .rx_ready(rx_ready));
`default_nettype wire

// File: sim/rqfd_mac_model.sv
// Receive MAC model: sends one generated frame per go pulse
`timescale 1ns/10ps
`default_nettype none
module rqfd_mac_model (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   go,
  input  wire logic [1:0]             kind,
  input  wire logic [15:0]            etyp,
  input  wire logic                   p2,
  input  wire logic [11:0]            flen,
  input  wire logic                   bad,
  input  wire logic                   coll,
  input  wire logic                   slow,
  input  wire logic                   rx_ready,
  output logic                        rx_valid,
  output var rqfd_pkg::rqfd_rx_beat_t rx_beat,
  output logic                        busy
);
  logic [11:0] idx;
  // Kind 0 broadcast, 1 multicast, 2 unicast destination
  function automatic rqfd_pkg::rqfd_rx_beat_t beat(logic [11:0] i);
    beat.data = i[7:0] ^ 8'h5a;
    if (i < 12'h006) beat.data = (kind == 2'h0) ? 8'hff : i[7:0];
    if (i == 12'h000 && kind != 2'h0) beat.data = {7'h0, kind == 2'h1};
    if (i == 12'h00c) beat.data = etyp[15:8];
    if (i == 12'h00d) beat.data = etyp[7:0];
    beat.last = (i == flen - 12'h001);
    beat.port_two = p2;
    beat.fcs_bad = bad;
    beat.collided = coll;
  endfunction
  // Idle data toggles so a stale byte is never mistaken for a fresh one
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      rx_valid <= 1'b0;
      idx <= 12'h0;
      rx_beat <= '0;
    end else if (!busy) begin
      if (go) begin
        busy <= 1'b1;
        rx_valid <= 1'b1;
        idx <= 12'h0;
        rx_beat <= beat(12'h0);
      end else begin
        rx_beat.data <= ~rx_beat.data;
      end
    end else if (rx_valid && rx_ready) begin
      idx <= idx + 12'h001;
      if (rx_beat.last || slow) begin
        busy <= !rx_beat.last;
        rx_valid <= 1'b0;
        rx_beat.data <= ~rx_beat.data;
      end else begin
        rx_beat <= beat(idx + 12'h001);
      end
    end else if (!rx_valid) begin
      rx_valid <= 1'b1;
      rx_beat <= beat(idx);
    end
  end
endmodule
`default_nettype wire

// File: sim/test_rx_queue_frame_descriptor.sv
// Testbench for the receive queue framer
`timescale 1ns/10ps
`default_nettype none
`define TB_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_rx_queue_frame_descriptor;
  logic                    sys_clk, reset, psel, penable, pwrite, go;
  logic                    pready, pslverr, rx_valid, rx_ready, busy;
  logic                    p2, bad, coll, slow;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata;
  logic [11:0]             flen;
  logic [1:0]              kind;
  logic [15:0]             etyp;
  rqfd_pkg::rqfd_rx_beat_t rx_beat;
  int                      miscompares, tests_run, cyc;

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end

  rqfd_framer dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_ready(rx_ready));
  rqfd_mac_model mac_u (.sys_clk(sys_clk), .reset(reset), .go(go),
    .kind(kind), .etyp(etyp), .p2(p2), .flen(flen), .bad(bad),
    .coll(coll), .slow(slow), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .busy(busy));

  // Ready, data and error are taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m = 32'hffffffff,
                    input logic ee = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `TB_CHK(r & m, x)
    `TB_CHK(e, ee)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    `TB_CHK(e, 1'b0)
  endtask

  task automatic send(input logic [1:0] k, input logic [15:0] t,
                      input logic p, input logic [11:0] l,
                      input logic b, input logic c, input logic s);
    @(posedge sys_clk);
    {kind, etyp, p2, flen, bad, coll, slow} <= {k, t, p, l, b, c, s};
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
    while (busy !== 1'b0) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] st(logic [1:0] k, logic [15:0] t,
                                     logic p, int l, logic b, logic c);
    st = 32'h8000;
    st[9:8] = p ? 2'h2 : 2'h1;
    st[7] = (k == 2'h0);
    st[6] = (k != 2'h2);
    st[5] = (k == 2'h2);
    st[3] = (t > 16'h05dc);
    st[2] = (l > 1518);
    st[1] = c || (l < 64);
    st[0] = b;
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    {sys_clk, reset, psel, penable, pwrite, paddr, pwdata} = '0;
    {go, kind, etyp, p2, flen, bad, coll, slow} = '0;
    {miscompares, tests_run, cyc} = '0;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
    $display("test idle done");
    send(2'h0, 16'h0800, 1'b0, 12'd64, 1'b0, 1'b0, 1'b0);
    send(2'h2, 16'h05dc, 1'b1, 12'd70, 1'b0, 1'b0, 1'b1);
    rd(8'h1c, 32'd142);
    rd(8'h04, st(2'h0, 16'h0800, 1'b0, 64, 1'b0, 1'b0));
    rd(8'h08, 32'd64);
    rd(8'h10, 32'hffff);
    wr(8'h0c, 32'hc);
    rd(8'h10, 32'h0008);
    rd(8'h0c, 32'h000e);
    wr(8'h14, 32'h1);
    rd(8'h04, st(2'h2, 16'h05dc, 1'b1, 70, 1'b0, 1'b0));
    rd(8'h08, 32'd70);
    wr(8'h14, 32'h1);
    rd(8'h04, 32'h0);
    $display("test queue done");
    wr(8'h00, 32'h2);
    rd(8'h00, 32'h2);
    send(2'h1, 16'h05dd, 1'b0, 12'd80, 1'b0, 1'b0, 1'b0);
    rd(8'h04, st(2'h1, 16'h05dd, 1'b0, 80, 1'b0, 1'b0));
    rd(8'h08, 32'd76);
    wr(8'h14, 32'h1);
    $display("test strip done");
    wr(8'h00, 32'h0);
    send(2'h2, 16'h0800, 1'b0, 12'd64, 1'b1, 1'b0, 1'b0);
    send(2'h2, 16'h0800, 1'b0, 12'd40, 1'b0, 1'b0, 1'b0);
    send(2'h0, 16'h0800, 1'b1, 12'd1519, 1'b0, 1'b0, 1'b0);
    rd(8'h04, 32'h0);
    rd(8'h18, 32'h3);
    $display("test filter done");
    wr(8'h00, 32'h1);
    send(2'h0, 16'h0800, 1'b0, 12'd1520, 1'b0, 1'b0, 1'b1);
    rd(8'h04, st(2'h0, 16'h0800, 1'b0, 1520, 1'b0, 1'b0));
    rd(8'h08, 32'd1520);
    wr(8'h0c, 32'd1518);
    rd(8'h10, 32'hb5b4);
    wr(8'h14, 32'h1);
    send(2'h2, 16'h0800, 1'b1, 12'd30, 1'b0, 1'b1, 1'b0);
    rd(8'h04, st(2'h2, 16'h0800, 1'b1, 30, 1'b0, 1'b1) & 32'hfff7,
       32'hfff7);
    rd(8'h08, 32'd30);
    wr(8'h14, 32'h1);
    send(2'h2, 16'h0800, 1'b1, 12'd64, 1'b1, 1'b0, 1'b0);
    rd(8'h04, st(2'h2, 16'h0800, 1'b1, 64, 1'b1, 1'b0));
    $display("test pass done");
    stop_test();
  end
endmodule
`default_nettype wire
